// >>> rtl/tpt_pkg.sv
package tpt_pkg;
    // ----------------------------------------------------------------
    // channel layout
    // ----------------------------------------------------------------
    localparam int NUM_CH = 16;
    localparam int RAM_DEPTH = 20;
    localparam int ADDR_W = 11;
    localparam logic [10:0] CH_STRIDE = 11'h040;
    localparam logic [10:0] CH_AREA_END = 11'h400;
    // ----------------------------------------------------------------
    // register offsets inside a channel block, and the absolute channel 0 RAM addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_TEMPLATE_SELECT = 6'h06;
    localparam logic [5:0] OFS_AMPLITUDE_SCALING = 6'h07;
    localparam logic [5:0] OFS_RAM_CONTROL = 6'h08;
    localparam logic [5:0] OFS_RAM_DATA = 6'h09;
    localparam logic [10:0] CH0_RAM_CONTROL = 11'h7C8;
    localparam logic [10:0] CH0_RAM_DATA = 11'h7C9;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SEL_ARB_BIT = 3;
    localparam int CTL_ENABLE_BIT = 6;
    localparam int CTL_DIR_BIT = 5;
    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic [3:0] SEL_RESET = 4'h2;
    localparam logic [3:0] SEL_E1_75 = 4'h0;
    localparam logic [3:0] SEL_E1_120 = 4'h1;
    localparam logic [3:0] SEL_DSX_SHORTEST = 4'h2;
    localparam logic [3:0] SEL_DSX_LONGEST = 4'h6;
    localparam logic [3:0] SEL_J1_110 = 4'h7;
    localparam logic [5:0] SCALE_RESET = 6'h36;
    localparam logic [5:0] SCALE_T1_NOMINAL = 6'h36;
    localparam logic [5:0] SCALE_E1_NOMINAL = 6'h21;
    localparam logic [4:0] SAMPLE_ADDR_RESET = 5'h00;
    localparam logic [4:0] SAMPLE_ADDR_LAST = 5'h13;
    // ----------------------------------------------------------------
    // amplitude steps and limits, in percent
    // ----------------------------------------------------------------
    localparam int T1_STEP_PCT = 2;
    localparam int E1_STEP_PCT = 3;
    localparam int T1_MAX_PCT = 20;
    localparam int E1_MAX_PCT = 100;
    localparam int MIN_PCT = -100;
endpackage

// >>> rtl/tpt_drv_if.sv
// per-channel settings toward the pulse driver stage
interface tpt_drv_if;
    logic [16:1][3:0] sel;
    logic [16:1][5:0] scale;
    logic e1Mode;
    logic [16:1][7:0] ampPct;
    modport src (output sel, output scale, output e1Mode, input ampPct);
    modport amp (input sel, input scale, input e1Mode, output ampPct);
endinterface

// >>> rtl/tpt_amp_stage.sv
// turns each channel's scaling code into a signed amplitude offset
module tpt_amp_stage
    import tpt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    tpt_drv_if.amp drv
);
    import tpt_pkg::*;

    typedef struct packed
    {
        logic [16:1][7:0] pct;
    } tpt_amp_t;

    tpt_amp_t s_q;
    tpt_amp_t s_d;

    // percent offset from nominal, clamped to the mode's range
    function automatic logic [7:0] tpt_pct(input logic [5:0] code, input logic isE1);
        int d;
        d = 0;
        if (isE1)
        begin
            d = (int'(code) - int'(SCALE_E1_NOMINAL)) * E1_STEP_PCT;
            if (d > E1_MAX_PCT) d = E1_MAX_PCT;
        end
        else
        begin
            d = (int'(code) - int'(SCALE_T1_NOMINAL)) * T1_STEP_PCT;
            if (d > T1_MAX_PCT) d = T1_MAX_PCT;
        end
        if (d < MIN_PCT) d = MIN_PCT;
        return d[7:0];
    endfunction

    // presets decide the mode, the arbitrary waveform follows e1Mode
    function automatic logic tpt_is_e1(input logic [3:0] sel, input logic e1Mode);
        return (sel == SEL_E1_75) || (sel == SEL_E1_120) || (sel[SEL_ARB_BIT] && e1Mode);
    endfunction

    // next amplitude offsets
    always_comb
    begin
        s_d = s_q;
        for (int c = 1; c <= NUM_CH; c++)
        begin
            s_d.pct[c] = tpt_pct(drv.scale[c], tpt_is_e1(drv.sel[c], drv.e1Mode));
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign drv.ampPct = s_q.pct;
endmodule

// >>> rtl/tpt_config.sv
// ----------------------------------------------------------------
// per-channel transmit pulse template configuration
// ----------------------------------------------------------------
//
// Design decision made here: the plain strobed port.
module tpt_config
    import tpt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [10:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [7:0] regRdData,
    input wire logic e1Mode,
    output logic [16:1][3:0] txTemplate,
    output logic [16:1] txArbEnable,
    output logic [16:1][5:0] txScaleCode,
    output logic [16:1][7:0] txAmpPct,
    output logic [16:0][19:0][6:0] txWaveform
);
    import tpt_pkg::*;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        REG_NONE,
        REG_SELECT,
        REG_SCALE,
        REG_CONTROL,
        REG_DATA
    } tpt_reg_t;

    typedef struct packed
    {
        tpt_reg_t kind;
        logic [4:0] ch;
    } tpt_hit_t;

    typedef struct packed
    {
        logic [16:1][3:0] sel;
        logic [16:1][5:0] scale;
        logic [16:0] enable;
        logic [16:0] dir;
        logic [16:0][4:0] sampleAddr;
        logic [16:0][6:0] sampleValue;
        logic [16:0][19:0][6:0] ram;
        logic [7:0] rdData;
        logic [16:1] arb;
    } tpt_state_t;

    // ----------------------------------------------------------------
    // state and helpers
    // ----------------------------------------------------------------
    tpt_state_t s_q;
    tpt_state_t s_d;
    tpt_hit_t hit;
    tpt_drv_if drv ();

    // address decode into register kind and channel
    function automatic tpt_hit_t tpt_decode(input logic [10:0] a);
        tpt_hit_t h;
        h.kind = REG_NONE;
        h.ch = 5'h00;
        if (a == CH0_RAM_CONTROL)
        begin
            h.kind = REG_CONTROL;
        end
        else if (a == CH0_RAM_DATA)
        begin
            h.kind = REG_DATA;
        end
        else if (a < CH_AREA_END)
        begin
            h.ch = {1'b0, a[9:6]} + 5'h01;
            case (a[5:0])
                OFS_TEMPLATE_SELECT: h.kind = REG_SELECT;
                OFS_AMPLITUDE_SCALING: h.kind = REG_SCALE;
                OFS_RAM_CONTROL: h.kind = REG_CONTROL;
                OFS_RAM_DATA: h.kind = REG_DATA;
                default: h.kind = REG_NONE;
            endcase
        end
        return h;
    endfunction

    // sample address code to RAM location
    function automatic logic [4:0] tpt_loc(input logic [4:0] code);
        return (code > SAMPLE_ADDR_LAST) ? SAMPLE_ADDR_LAST : code;
    endfunction

    // access gate: channel 0 has no selector and is open whenever its enable bit is set
    function automatic logic tpt_open(input tpt_state_t s, input logic [4:0] ch);
        logic arb;
        arb = 1'b1;
        if (ch != 5'h00)
        begin
            arb = s.sel[ch[3:0] == 4'h0 ? 16 : int'(ch)][SEL_ARB_BIT];
        end
        return arb && s.enable[ch];
    endfunction

    assign hit = tpt_decode(regAddr);

    // ----------------------------------------------------------------
    // register writes, RAM access and read data
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [4:0] loc;
        loc = tpt_loc(s_q.sampleAddr[hit.ch]);
        s_d = s_q;
        // selector top bit steers the driver to the arbitrary waveform
        for (int c = 1; c <= NUM_CH; c++)
        begin
            s_d.arb[c] = s_q.sel[c][SEL_ARB_BIT];
        end
        if (regWrStrobe)
        begin
            case (hit.kind)
                REG_SELECT: s_d.sel[hit.ch] = regWrData[3:0];
                REG_SCALE: s_d.scale[hit.ch] = regWrData[5:0];
                REG_CONTROL:
                begin
                    s_d.enable[hit.ch] = regWrData[CTL_ENABLE_BIT];
                    s_d.dir[hit.ch] = regWrData[CTL_DIR_BIT];
                    s_d.sampleAddr[hit.ch] = regWrData[4:0];
                end
                REG_DATA:
                begin
                    s_d.sampleValue[hit.ch] = regWrData[6:0];
                    // write direction stores the sample at once
                    if (tpt_open(s_q, hit.ch) && !s_q.dir[hit.ch])
                    begin
                        s_d.ram[hit.ch][loc] = regWrData[6:0];
                    end
                end
                default: ;
            endcase
        end
        // read data appears the cycle after the strobe and is held until the next cycle with ce, which clears it to zero or loads the next strobed read
        s_d.rdData = 8'h00;
        if (regRdStrobe)
        begin
            case (hit.kind)
                REG_SELECT: s_d.rdData = {4'h0, s_q.sel[hit.ch]};
                REG_SCALE: s_d.rdData = {2'h0, s_q.scale[hit.ch]};
                REG_CONTROL:
                begin
                    s_d.rdData = {1'b0, s_q.enable[hit.ch], s_q.dir[hit.ch],
                        s_q.sampleAddr[hit.ch]};
                end
                REG_DATA:
                begin
                    // read direction returns the RAM, else the held value
                    if (tpt_open(s_q, hit.ch) && s_q.dir[hit.ch])
                    begin
                        s_d.rdData = {1'b0, s_q.ram[hit.ch][loc]};
                    end
                    else
                    begin
                        s_d.rdData = {1'b0, s_q.sampleValue[hit.ch]};
                    end
                end
                default: s_d.rdData = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_q <= '0;
            for (int c = 1; c <= NUM_CH; c++)
            begin
                s_q.sel[c] <= SEL_RESET;
                s_q.scale[c] <= SCALE_RESET;
            end
            for (int c = 0; c <= NUM_CH; c++)
            begin
                s_q.sampleAddr[c] <= SAMPLE_ADDR_RESET;
            end
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // driver stage
    // ----------------------------------------------------------------
    assign drv.sel = s_q.sel;
    assign drv.scale = s_q.scale;
    assign drv.e1Mode = e1Mode;

    tpt_amp_stage u_amp
    (
        .mclk (mclk),
        .rst (rst),
        .ce (ce),
        .drv (drv.amp)
    );

    // template and scaling reach the drivers straight from the registers, arbitrary enable and amplitude one cycle later
    assign regRdData = s_q.rdData;
    assign txTemplate = s_q.sel;
    assign txArbEnable = s_q.arb;
    assign txScaleCode = s_q.scale;
    assign txAmpPct = drv.ampPct;
    assign txWaveform = s_q.ram;
endmodule

// >>> sim/tpt_config_chk.sv
// --------------------
// port-level checks
// --------------------
module tpt_config_chk
    import tpt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [10:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    input wire logic [7:0] regRdData,
    input wire logic e1Mode,
    input wire logic [16:1][3:0] txTemplate,
    input wire logic [16:1] txArbEnable,
    input wire logic [16:1][5:0] txScaleCode,
    input wire logic [16:1][7:0] txAmpPct
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // expected signed offset in percent
    function automatic logic [7:0] ampOf(logic [3:0] s, logic [5:0] c, logic e);
        int d;
        int hi;
        d = (s < 4'h2 || (s[3] && e)) ? (int'(c) - 33) * 3 : (int'(c) - 54) * 2;
        hi = (s < 4'h2 || (s[3] && e)) ? 100 : 20;
        d = (d > hi) ? hi : ((d < -100) ? -100 : d);
        return d[7:0];
    endfunction
    sequence sWr(a);
        ce && regWrStrobe && regAddr == a;
    endsequence
    sequence sRd(a);
        ce && regRdStrobe && regAddr == a;
    endsequence
    a_sel_write: assert property (sWr(11'h006) |=> txTemplate[1] == $past(regWrData[3:0]))
        else $error("selector write lost");
    a_scale_write: assert property (sWr(11'h007) |=> txScaleCode[1] == $past(regWrData[5:0]))
        else $error("scale write lost");
    a_sel_hold: assert property (!(ce && regWrStrobe && regAddr == 11'h006) |=> $stable(txTemplate[1]))
        else $error("selector changed");
    a_arb_track: assert property (ce |=> txArbEnable[1] == $past(txTemplate[1][3]))
        else $error("arbitrary enable wrong");
    a_amp_calc: assert property (ce && $past(ce) && $stable(e1Mode) |=>
        txAmpPct[1] == ampOf($past(txTemplate[1]), $past(txScaleCode[1]), $past(e1Mode)))
        else $error("amplitude offset wrong");
    a_rd_idle: assert property (ce && !regRdStrobe |=> regRdData == 8'h00)
        else $error("read data not idle");
    a_rd_sel: assert property (sRd(11'h006) |=> regRdData == {4'h0, $past(txTemplate[1])})
        else $error("selector read wrong");
    a_rd_scale: assert property (sRd(11'h007) |=> regRdData == {2'h0, $past(txScaleCode[1])})
        else $error("scale read wrong");
    a_rd_unmapped: assert property (ce && regRdStrobe && regAddr >= 11'h400
        && regAddr[10:1] != 10'h3E4 |=> regRdData == 8'h00) else $error("unmapped read not zero");
endmodule

bind tpt_config tpt_config_chk i_tpt_config_chk (.mclk, .rst, .ce, .regAddr, .regWrData,
    .regWrStrobe, .regRdStrobe, .regRdData, .e1Mode, .txTemplate, .txArbEnable,
    .txScaleCode, .txAmpPct);

// >>> sim/tx_pulse_template_config_bench.sv
module tx_pulse_template_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tpt_pkg::*;
    logic mclk = 0;
    logic rst = 1;
    logic ce = 1;
    logic [10:0] regAddr = '0;
    logic [7:0] regWrData = '0;
    logic regWrStrobe = 0;
    logic regRdStrobe = 0;
    logic e1Mode = 0;
    logic [7:0] regRdData;
    logic [16:1][3:0] txTemplate;
    logic [16:1] txArbEnable;
    logic [16:1][5:0] txScaleCode;
    logic [16:1][7:0] txAmpPct;
    logic [16:0][19:0][6:0] txWaveform;
    logic [3:0] mSel [17];
    logic [5:0] mScl [17];
    logic [6:0] mCtl [17];
    logic [6:0] mDat [17];
    logic [6:0] mRam [17][20];
    logic [7:0] sclTab [6] = '{8'h00, 8'h21, 8'h36, 8'h3F, 8'hE2, 8'h1F};
    logic [4:0] adrTab [4] = '{5'h00, 5'h12, 5'h13, 5'h1F};
    logic [10:0] a;
    int failures = 0;
    int cmpCount = 0;
    int seed = 71;
    int r;
    // ----------------------
    // clock, design, model
    // ----------------------
    always #12.5 mclk = ~mclk;
    tpt_config i_tpt_config (.mclk, .rst, .ce, .regAddr, .regWrData, .regWrStrobe,
        .regRdStrobe, .regRdData, .e1Mode, .txTemplate, .txArbEnable, .txScaleCode,
        .txAmpPct, .txWaveform);
    function automatic int chOf(logic [10:0] ad);
        if (ad == CH0_RAM_CONTROL || ad == CH0_RAM_DATA) return 0;
        if (ad < CH_AREA_END && ad[5:0] >= 6'h06 && ad[5:0] <= 6'h09) return ad[9:6] + 1;
        return -1;
    endfunction
    function automatic logic acc(int c, logic dir);
        return mSel[c][3] && mCtl[c][6] && mCtl[c][5] == dir;
    endfunction
    function automatic int loc(int c);
        return (mCtl[c][4:0] > 5'h13) ? 19 : mCtl[c][4:0];
    endfunction
    // expected amplitude offset from the model state
    function automatic logic [7:0] pctOf(int c);
        int d;
        int hi;
        logic e1;
        e1 = (mSel[c] == SEL_E1_75) || (mSel[c] == SEL_E1_120) || (mSel[c][3] && e1Mode);
        hi = e1 ? E1_MAX_PCT : T1_MAX_PCT;
        d = e1 ? (int'(mScl[c]) - int'(SCALE_E1_NOMINAL)) * E1_STEP_PCT
            : (int'(mScl[c]) - int'(SCALE_T1_NOMINAL)) * T1_STEP_PCT;
        d = (d > hi) ? hi : ((d < MIN_PCT) ? MIN_PCT : d);
        return d[7:0];
    endfunction
    task automatic cmp(logic [7:0] got, logic [7:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [10:0] ad, logic [7:0] d, logic en = 1'b1);
        int c;
        c = chOf(ad);
        ce <= en;
        regAddr <= ad;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        regRdStrobe <= 1'b0;
        if (en && c >= 0)
            case (ad[5:0])
                6'h06: mSel[c] = d[3:0];
                6'h07: mScl[c] = d[5:0];
                6'h08: mCtl[c] = d[6:0];
                default:
                begin
                    mDat[c] = d[6:0];
                    if (acc(c, 1'b0)) mRam[c][loc(c)] = d[6:0];
                end
            endcase
        @(posedge mclk);
    endtask
    task automatic rd(logic [10:0] ad);
        logic [7:0] e;
        int c;
        c = chOf(ad);
        e = 8'h00;
        if (c >= 0)
            case (ad[5:0])
                6'h06: e = {4'h0, mSel[c]};
                6'h07: e = {2'h0, mScl[c]};
                6'h08: e = {1'b0, mCtl[c]};
                default: e = {1'b0, acc(c, 1'b1) ? mRam[c][loc(c)] : mDat[c]};
            endcase
        ce <= 1'b1;
        regAddr <= ad;
        regRdStrobe <= 1'b1;
        regWrStrobe <= 1'b0;
        @(posedge mclk);
        regRdStrobe <= 1'b0;
        @(negedge mclk);
        cmp(regRdData, e);
        @(posedge mclk);
    endtask
    // bus idle, let the driver outputs settle, then compare all channels
    task automatic check();
        regWrStrobe <= 1'b0;
        regRdStrobe <= 1'b0;
        ce <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        for (int c = 0; c < 17; c++)
        begin
            for (int i = 0; i < 20; i++)
                cmp({1'b0, txWaveform[c][i]}, {1'b0, mRam[c][i]});
            if (c > 0)
            begin
                cmp({4'h0, txTemplate[c]}, {4'h0, mSel[c]});
                cmp({2'h0, txScaleCode[c]}, {2'h0, mScl[c]});
                cmp({7'h0, txArbEnable[c]}, {7'h0, mSel[c][3]});
                cmp(txAmpPct[c], pctOf(c));
            end
        end
        @(posedge mclk);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // reset, directed cases, random traffic
    initial
    begin
        for (int c = 0; c < 17; c++)
        begin
            mSel[c] = (c == 0) ? 4'h8 : SEL_RESET;
            mScl[c] = SCALE_RESET;
            mCtl[c] = '0;
            mDat[c] = '0;
            for (int i = 0; i < 20; i++) mRam[c][i] = '0;
        end
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (int c = 0; c < 16; c++)
            for (int o = 6; o < 11; o++)
                rd({1'b0, c[3:0], o[5:0]});
        check();
        for (int k = 0; k < 32; k++)
        begin
            e1Mode <= k[4];
            wr(11'h006, 8'hF0 | k[3:0]);
            wr(11'h007, sclTab[k % 6]);
            rd(11'h006);
            rd(11'h007);
        end
        wr(11'h106, 8'h09);
        for (int k = 0; k < 8; k++)
        begin
            a = k[2] ? 11'h7C8 : 11'h108;
            wr(a, {3'b010, adrTab[k % 4]});
            wr(a + 11'h001, 8'h40 | k[7:0]);
            wr(a, {3'b011, adrTab[k % 4]});
            rd(a + 11'h001);
            wr(a, 8'h00);
            wr(a + 11'h001, 8'h15, k[0]);
            rd(a + 11'h001);
        end
        check();
        for (int k = 0; k < 2000; k++)
        begin
            r = $random(seed);
            e1Mode <= r[20];
            case (r[2:0])
                3'd0: a = 11'h7C8 | r[3];
                3'd1: a = r[13:3];
                default: a = {1'b0, r[6:3], 6'h06 + r[9:8]};
            endcase
            if (r[10]) rd(a);
            else wr(a, r[18:11], r[23:21] != 0);
        end
        check();
        finish_test();
    end
endmodule
